/* File: shared/ebus_map.vh */
// constants for the external bus address, data and chip-select block
`ifndef EBUS_MAP_VH
`define EBUS_MAP_VH
`define EBUS_PF_WE        2'h0
`define EBUS_PF_CS        2'h1
`define EBUS_PF_ADDR      2'h2
`define EBUS_PS_32        2'h0
`define EBUS_PS_8         2'h1
`define EBUS_PS_16        2'h2
`define EBUS_BOOT_WAIT    4'hF
`define EBUS_IACK_UPPER   23'h7FFFFF
`define EBUS_XT_NORMAL    2'h0
`define EBUS_XT_CPUSPACE  2'h1
`define EBUS_XT_IACK      2'h2
`define EBUS_AM_CORE      2'h0
`define EBUS_AM_ROW       2'h1
`define EBUS_AM_COL       2'h2
`define EBUS_AM_IACK      2'h3
`define EBUS_CS_COUNT     8
`endif

/* File: src/ebus_cs_match.v */
// one chip-select region comparator
module ebus_cs_match #(
   parameter AW = 28
) (
   // region setup
   input  wire [AW-1:0] baseAddr,
   input  wire [AW-1:0] maskAddr,
   input  wire          regionOn,
   input  wire          cpuSpaceOn,
   // transfer
   input  wire [AW-1:0] xferAddr,
   input  wire          cpuSpace,
   output wire          hit
);
   wire addrHit;
   assign addrHit = ((xferAddr ^ baseAddr) & ~maskAddr) == {AW{1'b0}};
   assign hit = regionOn & ((addrHit & ~cpuSpace) | (cpuSpace & cpuSpaceOn));
endmodule // ebus_cs_match

/* File: src/ebus_we_decode.v */
// byte write enable decode from size, low address and port size
module ebus_we_decode (
   // transfer shape
   input  wire [1:0] xferSize,
   input  wire [1:0] lowAddr,
   input  wire [1:0] portSize,
   input  wire       isWrite,
   output reg  [3:0] weLanes
);
   `include "ebus_map.vh"
   always @* begin
      weLanes = 4'h0;
      if (isWrite) begin
         if (portSize == `EBUS_PS_8) begin
            weLanes = 4'h1;
         end else if (portSize == `EBUS_PS_16) begin
            if (xferSize == 2'h1)
               weLanes = lowAddr[0] ? 4'h2 : 4'h1;
            else
               weLanes = 4'h3;
         end else begin
            case (xferSize)
               2'h1: weLanes = 4'h1 << lowAddr;
               2'h2: weLanes = lowAddr[1] ? 4'hC : 4'h3;
               default: weLanes = 4'hF;
            endcase
         end
      end
   end
endmodule // ebus_we_decode

/* File: src/ebus_pin_unit.v */
// external bus pin logic: address, data, chip-selects, write enables
`include "ebus_map.vh"
// What this block does
// [R1] iack: ones high, level, zero low bits
// [R2] 24 dedicated lines plus four configurable ones
// [R3] upper pins: address, cs or we; reset we
// [R4] all upper as address gives 256 Mbytes
// [R5] upper address timed with lower, valid at start
// [R6] core cs transfers drive, burst increments low
// [R7] core dram: row then column address
// [R8] alternate master cs transfers: address undriven
// [R9] slave dram: master releases, device drives row/col
// [R10] read data captured on any acknowledge edge
// [R11] reset pins set initial default port width
// [R12] per region and dram port width, else global
// [R13] byte/word/long; writes drive all 32 lines
// [R14] eight active-low chip-select outputs
// [R15] base, mask, size, burst, wait, termination
// [R16] reset disables chip-selects one to seven
// [R17] chip-select one optionally on cpu space
// [R18] chip-select zero boot, only one at reset
// [R19] reset pins set boot size and termination
// [R20] we zero high byte down to three low
// [R21] top level pin low: no auto-ack, else 15 waits
// [R22] buses released when not actively driving
module ebus_pin_unit #(
   parameter NCS = `EBUS_CS_COUNT,
   parameter AW  = 28
) (
   // clock and reset
   input  wire            core_clk,
   input  wire            rst_n,
   // core request
   input  wire            coreReq,
   input  wire [AW-1:0]   coreAddr,
   input  wire            coreWrite,
   input  wire [1:0]      coreSize,
   input  wire            coreBurst,
   input  wire [1:0]      coreXferType,
   input  wire [2:0]      coreIackLevel,
   input  wire [31:0]     coreWrData,
   output reg  [31:0]     coreRdData_ff,
   output reg             coreDone_ff,
   // dram control from the dram controller
   input  wire            dramHit,
   input  wire [1:0]      dramPortSize,
   input  wire            dramRowPhase,
   input  wire            dramColPhase,
   input  wire [AW-1:0]   dramRowAddr,
   input  wire [AW-1:0]   dramColAddr,
   // alternate master
   input  wire            altMaster,
   input  wire            slaveDramMode,
   // configuration
   input  wire [7:0]      pin_function_select_reg,
   input  wire [NCS*AW-1:0] csBase,
   input  wire [NCS*AW-1:0] csMask,
   input  wire [NCS-1:0]  csEnableWr,
   input  wire [NCS-1:0]  csEnableVal,
   input  wire [2*NCS-1:0] csPortSize,
   input  wire [NCS-1:0]  csBurstOk,
   input  wire [4*NCS-1:0] csWaitStates,
   input  wire [NCS-1:0]  csAutoAck,
   input  wire            csOneCpuSpace,
   input  wire            bootCfgWr,
   input  wire [1:0]      bootPortSizeVal,
   input  wire            bootAutoAckVal,
   input  wire [3:0]      bootWaitVal,
   input  wire            defPortSizeWr,
   input  wire [1:0]      defPortSizeVal,
   // external pins
   input  wire [2:0]      interrupt_level_pins,
   input  wire            transfer_begin_strobe_in,
   input  wire            sync_transfer_ack,
   input  wire            extAckEnable,
   input  wire [31:0]     dataIn,
   input  wire [AW-1:0]   addrIn,
   output reg             transfer_begin_strobe_ff,
   output reg  [AW-1:0]   addrOut_ff,
   output reg  [AW-1:0]   addrOe_ff,
   output reg  [31:0]     dataOut_ff,
   output reg             dataOe_ff,
   output reg  [NCS-1:0]  csOut_n_ff,
   output reg  [3:0]      weOut_n_ff,
   output reg  [1:0]      activePortSize_ff,
   output reg  [1:0]      defPortSize_ff,
   output reg  [1:0]      bootPortSize_ff,
   output reg             bootAutoAck_ff,
   output reg  [3:0]      bootWait_ff,
   output reg             busBusy_ff
);
   localparam ST_IDLE = 2'h0;
   localparam ST_ADDR = 2'h1;
   localparam ST_WAIT = 2'h2;
   // pin synchronisers
   reg  [2:0] iplS1_ff;
   reg  [2:0] iplS2_ff;
   reg        tsS1_ff;
   reg        tsS2_ff;
   reg        ackS1_ff;
   reg        ackS2_ff;
   reg [31:0] dInS1_ff;
   reg [31:0] dInS2_ff;
   reg [AW-1:0] aInS1_ff;
   reg [AW-1:0] aInS2_ff;
   always @(posedge core_clk) begin
      iplS1_ff <= interrupt_level_pins;
      iplS2_ff <= iplS1_ff;
      tsS1_ff  <= transfer_begin_strobe_in;
      tsS2_ff  <= tsS1_ff;
      ackS1_ff <= sync_transfer_ack;
      ackS2_ff <= ackS1_ff;
      dInS1_ff <= dataIn;
      dInS2_ff <= dInS1_ff;
      aInS1_ff <= addrIn;
      aInS2_ff <= aInS1_ff;
   end
   // chip-select enable state
   reg [NCS-1:0] csOn_ff;
   integer k;
   always @(posedge core_clk) begin
      if (!rst_n) begin
         csOn_ff <= {{(NCS-1){1'b0}}, 1'b1}; // R16 R18
      end else begin
         for (k = 0; k < NCS; k = k + 1)
            if (csEnableWr[k])
               csOn_ff[k] <= csEnableVal[k];
      end
   end
   // reset-time strap capture, sampled every cycle while reset is low
   always @(posedge core_clk) begin
      if (!rst_n) begin
         defPortSize_ff  <= iplS2_ff[1:0]; // R11
         bootPortSize_ff <= iplS2_ff[1:0]; // R19
         bootAutoAck_ff  <= iplS2_ff[2]; // R19 R21
         bootWait_ff     <= `EBUS_BOOT_WAIT; // R21
      end else begin
         if (defPortSizeWr)
            defPortSize_ff <= defPortSizeVal;
         if (bootCfgWr) begin
            bootPortSize_ff <= bootPortSizeVal;
            bootAutoAck_ff  <= bootAutoAckVal;
            bootWait_ff     <= bootWaitVal;
         end
      end
   end
   // transfer context
   reg [1:0]    state_ff;
   reg [AW-1:0] curAddr_ff;
   reg          curWrite_ff;
   reg [1:0]    curSize_ff;
   reg          curBurst_ff;
   reg [1:0]    curType_ff;
   reg [2:0]    curLevel_ff;
   reg [31:0]   curData_ff;
   reg [1:0]    beat_ff;
   reg [3:0]    waitCnt_ff;
   reg          slaveXfer_ff;
   wire          cpuSpace;
   wire [NCS-1:0] hits;
   assign cpuSpace = curType_ff != `EBUS_XT_NORMAL;
   genvar g;
   generate
      for (g = 0; g < NCS; g = g + 1) begin : gCs
         ebus_cs_match #(.AW(AW)) uMatch (
            .baseAddr   (csBase[g*AW +: AW]),
            .maskAddr   (csMask[g*AW +: AW]),
            .regionOn   (csOn_ff[g]),
            .cpuSpaceOn ((g == 1) ? csOneCpuSpace : 1'b0), // R17
            .xferAddr   (curAddr_ff),
            .cpuSpace   (cpuSpace),
            .hit        (hits[g])
         );
      end
   endgenerate
   // lowest numbered hit wins; settings of the selected region
   reg [2:0] hitIdx;
   reg       anyHit;
   reg [1:0] selSize;
   reg [3:0] selWait;
   reg       selAuto;
   reg       selBurst;
   integer   j;
   always @* begin
      hitIdx   = 3'h0;
      anyHit   = 1'b0;
      for (j = NCS - 1; j >= 0; j = j - 1)
         if (hits[j]) begin
            hitIdx = j[2:0];
            anyHit = 1'b1;
         end
      if (anyHit && hitIdx == 3'h0) begin
         selSize = bootPortSize_ff; // R18
         selWait = bootWait_ff;
         selAuto = bootAutoAck_ff;
         selBurst = csBurstOk[0];
      end else if (anyHit) begin
         selSize = csPortSize[2*hitIdx +: 2]; // R12 R15
         selWait = csWaitStates[4*hitIdx +: 4];
         selAuto = csAutoAck[hitIdx];
         selBurst = csBurstOk[hitIdx];
      end else if (dramHit) begin
         selSize = dramPortSize; // R12
         selWait = 4'h0;
         selAuto = 1'b0;
         selBurst = 1'b1;
      end else begin
         selSize = defPortSize_ff; // R12
         selWait = 4'h0;
         selAuto = 1'b0;
         selBurst = 1'b0;
      end
   end
   // byte write enables
   wire [3:0] weLanes;
   ebus_we_decode uWe (
      .xferSize (curSize_ff),
      .lowAddr  (curAddr_ff[1:0]),
      .portSize (selSize),
      .isWrite  (curWrite_ff),
      .weLanes  (weLanes)
   );
   // address to present
   reg [AW-1:0] nxtAddrVal;
   reg [1:0]    addrMode;
   always @* begin
      if (curType_ff == `EBUS_XT_IACK)
         addrMode = `EBUS_AM_IACK;
      else if ((dramHit && !slaveXfer_ff) || slaveXfer_ff)
         addrMode = dramColPhase ? `EBUS_AM_COL :
                    (dramRowPhase ? `EBUS_AM_ROW : `EBUS_AM_CORE);
      else
         addrMode = `EBUS_AM_CORE;
      case (addrMode)
         `EBUS_AM_IACK: nxtAddrVal = {`EBUS_IACK_UPPER, curLevel_ff, 2'h0}; // R1
         `EBUS_AM_ROW:  nxtAddrVal = dramRowAddr; // R7 R9
         `EBUS_AM_COL:  nxtAddrVal = dramColAddr; // R7 R9
         default:       nxtAddrVal = curAddr_ff;
      endcase
   end
   // acknowledge
   wire extAck;
   wire intAck;
   wire anyAck;
   assign extAck = extAckEnable & ackS2_ff;
   assign intAck = selAuto & (waitCnt_ff == 4'h0);
   assign anyAck = (state_ff == ST_WAIT) & (extAck | intAck);

   wire lastBeat;
   assign lastBeat = !curBurst_ff || !selBurst || beat_ff == 2'h3;
   wire driveAddr;
   assign driveAddr = !altMaster || slaveXfer_ff && (dramRowPhase || dramColPhase);

   always @(posedge core_clk) begin
      if (!rst_n) begin
         state_ff    <= ST_IDLE;
         curAddr_ff  <= {AW{1'b0}};
         curWrite_ff <= 1'b0;
         curSize_ff  <= 2'h0;
         curBurst_ff <= 1'b0;
         curType_ff  <= `EBUS_XT_NORMAL;
         curLevel_ff <= 3'h0;
         curData_ff  <= 32'h0;
         beat_ff     <= 2'h0;
         waitCnt_ff  <= 4'h0;
         slaveXfer_ff <= 1'b0;
         coreRdData_ff <= 32'h0;
         coreDone_ff <= 1'b0;
         transfer_begin_strobe_ff <= 1'b0;
         busBusy_ff  <= 1'b0;
      end else begin
         coreDone_ff <= 1'b0;
         transfer_begin_strobe_ff <= 1'b0;
         case (state_ff)
            ST_IDLE: begin
               if (altMaster && slaveDramMode && tsS2_ff) begin
                  curAddr_ff   <= aInS2_ff; // R9
                  curWrite_ff  <= 1'b0;
                  curType_ff   <= `EBUS_XT_NORMAL;
                  curBurst_ff  <= 1'b0;
                  slaveXfer_ff <= 1'b1;
                  state_ff     <= ST_WAIT;
                  busBusy_ff   <= 1'b1;
               end else if (coreReq && !altMaster) begin
                  curAddr_ff  <= coreAddr;
                  curWrite_ff <= coreWrite;
                  curSize_ff  <= coreSize;
                  curBurst_ff <= coreBurst;
                  curType_ff  <= coreXferType;
                  curLevel_ff <= coreIackLevel;
                  curData_ff  <= coreWrData;
                  slaveXfer_ff <= 1'b0;
                  beat_ff     <= 2'h0;
                  state_ff    <= ST_ADDR;
                  busBusy_ff  <= 1'b1;
               end
            end
            ST_ADDR: begin
               transfer_begin_strobe_ff <= 1'b1; // R5
               waitCnt_ff <= selWait;
               state_ff   <= ST_WAIT;
            end
            ST_WAIT: begin
               if (waitCnt_ff != 4'h0)
                  waitCnt_ff <= waitCnt_ff - 4'h1;
               if (slaveXfer_ff) begin
                  if (!slaveDramMode || !altMaster) begin
                     slaveXfer_ff <= 1'b0;
                     state_ff     <= ST_IDLE;
                     busBusy_ff   <= 1'b0;
                  end
               end else if (anyAck) begin
                  if (!curWrite_ff)
                     coreRdData_ff <= dInS2_ff; // R10
                  if (lastBeat) begin
                     coreDone_ff <= 1'b1;
                     state_ff    <= ST_IDLE;
                     busBusy_ff  <= 1'b0;
                  end else begin
                     beat_ff <= beat_ff + 2'h1;
                     curAddr_ff[3:2] <= curAddr_ff[3:2] + 2'h1; // R6
                     waitCnt_ff <= selWait;
                  end
               end
            end
            default: state_ff <= ST_IDLE;
         endcase
      end
   end

   // pin drive
   integer p;
   always @(posedge core_clk) begin
      if (!rst_n) begin
         addrOut_ff  <= {AW{1'b0}};
         addrOe_ff   <= {AW{1'b0}};
         dataOut_ff  <= 32'h0;
         dataOe_ff   <= 1'b0;
         csOut_n_ff  <= {NCS{1'b1}};
         weOut_n_ff  <= 4'hF;
         activePortSize_ff <= `EBUS_PS_32;
      end else begin
         addrOut_ff <= nxtAddrVal;
         activePortSize_ff <= selSize;
         if (busBusy_ff && driveAddr) begin
            addrOe_ff[23:0] <= {24{1'b1}}; // R2 R8 R22
            for (p = 0; p < 4; p = p + 1)
               addrOe_ff[24+p] <= pin_function_select_reg[2*p +: 2] == `EBUS_PF_ADDR; // R3 R4
         end else begin
            addrOe_ff <= {AW{1'b0}}; // R8 R22
         end
         dataOut_ff <= curData_ff; // R13
         dataOe_ff  <= busBusy_ff && curWrite_ff && !slaveXfer_ff; // R13 R22
         for (p = 0; p < NCS; p = p + 1)
            csOut_n_ff[p] <= !(busBusy_ff && !altMaster && state_ff != ST_IDLE
                               && anyHit && hitIdx == p); // R14
         // high-order selects reach pins only when steered there
         for (p = 4; p < NCS; p = p + 1)
            if (pin_function_select_reg[2*(p-4) +: 2] != `EBUS_PF_CS)
               csOut_n_ff[p] <= 1'b1; // R3
         for (p = 0; p < 4; p = p + 1)
            weOut_n_ff[p] <= !(busBusy_ff && state_ff == ST_WAIT && weLanes[p]
                               && pin_function_select_reg[2*(3-p) +: 2] == `EBUS_PF_WE); // R20
      end
   end
endmodule // ebus_pin_unit

/* File: bench/ebus_pin_sva.sv */
// port assertions for the external bus pin unit
`include "ebus_map.vh"
module ebus_pin_sva #(
   parameter NCS = 8,
   parameter AW  = 28
) (
   // clock and reset
   input wire           core_clk,
   input wire           rst_n,
   // core side
   input wire           coreWrite,
   input wire [1:0]     coreXferType,
   input wire [2:0]     coreIackLevel,
   input wire [31:0]    coreWrData,
   input wire           altMaster,
   input wire           slaveDramMode,
   input wire [7:0]     pin_function_select_reg,
   // pins
   input wire           transfer_begin_strobe_ff,
   input wire [AW-1:0]  addrOut_ff,
   input wire [AW-1:0]  addrOe_ff,
   input wire [31:0]    dataOut_ff,
   input wire           dataOe_ff,
   input wire [NCS-1:0] csOut_n_ff,
   input wire [3:0]     weOut_n_ff,
   input wire [3:0]     bootWait_ff,
   input wire           busBusy_ff
);
   timeunit 1ns;
   timeprecision 100ps;
   wire [3:0] upAddr;
   wire       stb;
   assign stb = transfer_begin_strobe_ff;
   assign upAddr[0] = pin_function_select_reg[1:0] == `EBUS_PF_ADDR;
   assign upAddr[1] = pin_function_select_reg[3:2] == `EBUS_PF_ADDR;
   assign upAddr[2] = pin_function_select_reg[5:4] == `EBUS_PF_ADDR;
   assign upAddr[3] = pin_function_select_reg[7:6] == `EBUS_PF_ADDR;
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   sequence launchSeq;
      $rose(busBusy_ff) ##1 stb;
   endsequence
   iack_addr_a: assert property (stb && coreXferType == `EBUS_XT_IACK |->
      addrOut_ff[27:5] == `EBUS_IACK_UPPER && addrOut_ff[4:2] == coreIackLevel
      && addrOut_ff[1:0] == 2'h0) else $error("iack address wrong");
   strobe_start_a: assert property ($rose(busBusy_ff) && !altMaster |-> launchSeq)
      else $error("strobe not one cycle after start");
   strobe_pulse_a: assert property (launchSeq |=> !stb) else $error("strobe too long");
   low_addr_a: assert property (stb |-> addrOe_ff[23:0] == 24'hFFFFFF)
      else $error("low address not driven");
   upper_pin_a: assert property (stb |-> addrOe_ff[27:24] == upAddr)
      else $error("upper pin drive mismatch");
   alt_quiet_a: assert property ((altMaster && !slaveDramMode && !busBusy_ff)[*3]
      |-> addrOe_ff == '0) else $error("address driven for alternate master");
   write_data_a: assert property (stb && coreWrite |-> dataOe_ff
      && dataOut_ff == coreWrData) else $error("write data not driven");
   idle_release_a: assert property ((!busBusy_ff)[*2] |-> !dataOe_ff)
      else $error("data driven while idle");
   one_cs_a: assert property (stb |-> $onehot0(~csOut_n_ff))
      else $error("several chip-selects low");
   reset_idle_a: assert property (disable iff (1'b0) !rst_n |=> &csOut_n_ff
      && &weOut_n_ff && addrOe_ff == '0 && bootWait_ff == `EBUS_BOOT_WAIT)
      else $error("reset state wrong");
endmodule // ebus_pin_sva

/* File: bench/ebus_ext_mem.sv */
// far side memory model: acks each start, returns address-derived data
module ebus_ext_mem (
   // bus side
   input  wire         core_clk,
   input  wire         strobe,
   input  wire [7:0]   csSel_n,
   input  wire         dataOe,
   input  wire [27:0]  addr,
   input  wire [3:0]   ackDelay,
   // answers
   output logic        ack,
   output logic [31:0] rdData
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [27:0] lat = '0;
   logic [3:0]  cnt = '0;
   logic [2:0]  keep = '0;
   logic        act = 1'h0;
   initial ack = 1'h0;
   initial rdData = 32'h5A5A5A5A;
   always @(posedge core_clk) begin
      ack <= 1'h0;
      if (keep != 3'h0) keep <= keep - 3'h1;
      if (strobe) begin
         lat <= addr;
         act <= 1'h1;
         cnt <= ackDelay;
      end else if (act && cnt == 4'h0) begin
         ack <= 1'h1;
         act <= 1'h0;
         keep <= 3'h6;
      end else if (act) cnt <= cnt - 4'h1;
      if ((act || keep != 3'h0 || csSel_n != 8'hFF) && !dataOe)
         rdData <= {lat[15:0] ^ 16'hA5C3, ~lat[15:0]};
      else
         rdData <= ~rdData;
   end
endmodule // ebus_ext_mem

/* File: bench/tb.sv */
// self-checking bench for the external bus pin unit
`include "ebus_map.vh"
module tb;
   timeunit 1ns;
   timeprecision 100ps;
   localparam NCS = 8;
   localparam AW  = 28;
   logic core_clk = 0, rst_n = 0, coreReq = 0, coreWrite = 0, coreBurst = 0, dramHit = 0;
   logic dramRowPhase = 0, dramColPhase = 0, altMaster = 0, slaveDramMode = 0;
   logic csOneCpuSpace = 0, bootCfgWr = 0, bootAutoAckVal = 0, defPortSizeWr = 0;
   logic transfer_begin_strobe_in = 0, extAckEnable = 1;
   logic [1:0] coreSize = 0, coreXferType = 0, dramPortSize = 0;
   logic [1:0] bootPortSizeVal = 0, defPortSizeVal = 0;
   logic [2:0] coreIackLevel = 0, interrupt_level_pins = 3'h5;
   logic [3:0] bootWaitVal = 0;
   logic [7:0] pin_function_select_reg = 0, csEnableWr = 0, csEnableVal = 0;
   logic [7:0] csBurstOk = 0, csAutoAck = 0;
   logic [15:0] csPortSize = 0;
   logic [31:0] coreWrData = 0, csWaitStates = 0;
   logic [AW-1:0] coreAddr = 0, dramRowAddr = 0, dramColAddr = 0, addrIn = 0;
   logic [NCS*AW-1:0] csBase = 0, csMask = 0;
   wire [31:0] coreRdData_ff, dataIn, dataOut_ff;
   wire coreDone_ff, sync_transfer_ack, transfer_begin_strobe_ff, dataOe_ff;
   wire bootAutoAck_ff, busBusy_ff;
   wire [AW-1:0] addrOut_ff, addrOe_ff;
   wire [NCS-1:0] csOut_n_ff;
   wire [3:0] weOut_n_ff, bootWait_ff;
   wire [1:0] activePortSize_ff, defPortSize_ff, bootPortSize_ff;
   int miscompares = 0;
   int compares = 0;
   logic [27:0] stAddr, stOe;
   logic [7:0]  stCs;
   logic [1:0]  stPs;
   ebus_pin_unit #(.NCS(NCS), .AW(AW)) dut_u (.*);
   ebus_ext_mem mem_u (.core_clk(core_clk), .strobe(transfer_begin_strobe_ff),
      .csSel_n(csOut_n_ff), .dataOe(dataOe_ff), .addr(addrOut_ff), .ackDelay(4'h4),
      .ack(sync_transfer_ack), .rdData(dataIn));
   always #2.5 core_clk = ~core_clk;
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      compares++;
      if (got !== exp) begin
         miscompares++;
         $display("FAIL %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask
   task automatic finish_test;
      $display("compares %0d miscompares %0d", compares, miscompares);
      if (miscompares == 0 && compares > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   task automatic xfer(input logic [27:0] a, input logic wr, input logic [1:0] xt,
                       input logic [31:0] wd);
      int n;
      @(posedge core_clk);
      coreAddr <= a;
      coreWrite <= wr;
      coreXferType <= xt;
      coreWrData <= wd;
      coreReq <= 1'h1;
      @(posedge core_clk);
      coreReq <= 1'h0;
      #1;
      n = 0;
      while (transfer_begin_strobe_ff !== 1'h1 && n < 20) begin
         @(posedge core_clk);
         #1;
         n++;
      end
      stAddr = addrOut_ff;
      stOe = addrOe_ff;
      stCs = csOut_n_ff;
      stPs = activePortSize_ff;
      chk(n < 20, 1'h1, "no strobe");
      n = 0;
      while (coreDone_ff !== 1'h1 && n < 60) begin
         @(posedge core_clk);
         #1;
         n++;
      end
      chk(n < 60, 1'h1, "no done");
   endtask
   task automatic do_reset(input logic [2:0] pins);
      @(posedge core_clk);
      rst_n <= 1'h0;
      interrupt_level_pins <= pins;
      repeat (6) @(posedge core_clk);
      rst_n <= 1'h1;
      @(posedge core_clk);
      #1;
      chk(csOut_n_ff, 8'hFF, "cs after reset");
      chk(weOut_n_ff, 4'hF, "we after reset");
      chk(addrOe_ff, 28'h0, "addr oe after reset");
      chk(bootPortSize_ff, pins[1:0], "boot size");
      chk(defPortSize_ff, pins[1:0], "default size");
      chk(bootAutoAck_ff, pins[2], "boot auto ack");
      chk(bootWait_ff, 4'hF, "boot waits");
   endtask
   initial begin
      #20000;
      miscompares++;
      finish_test;
   end
   initial begin
      do_reset(3'h5);
      @(posedge core_clk);
      csBase[55:28] <= 28'hFFFFFF4;
      csAutoAck <= 8'h02;
      csWaitStates[7:4] <= 4'h2;
      csPortSize[3:2] <= 2'h2;
      csOneCpuSpace <= 1'h1;
      csEnableWr <= 8'h02;
      csEnableVal <= 8'h02;
      defPortSizeWr <= 1'h1;
      defPortSizeVal <= `EBUS_PS_32;
      coreSize <= 2'h1;
      pin_function_select_reg <= 8'h86;
      coreIackLevel <= 3'h5;
      @(posedge core_clk);
      csEnableWr <= 8'h00;
      defPortSizeWr <= 1'h0;
      xfer(28'h0000000, 1'h0, `EBUS_XT_NORMAL, 32'h0);
      chk(stCs, 8'hFE, "boot cs");
      chk(stPs, `EBUS_PS_8, "boot port size");
      chk(coreRdData_ff, 32'hA5C3FFFF, "read data");
      xfer(28'h9000001, 1'h1, `EBUS_XT_NORMAL, 32'h1234ABCD);
      chk(stAddr[27:24], 4'h9, "upper address");
      chk(stOe, 28'h9FFFFFF, "address drive");
      chk(stPs, `EBUS_PS_32, "default port size");
      chk(dataOut_ff, 32'h1234ABCD, "write data");
      chk(weOut_n_ff, 4'hD, "byte write enable");
      xfer(28'h0000000, 1'h0, `EBUS_XT_IACK, 32'h0);
      chk(stAddr, 28'hFFFFFF4, "iack address");
      chk(stCs, 8'hFD, "cpu space cs");
      chk(stPs, `EBUS_PS_16, "cs port size");
      @(posedge core_clk);
      altMaster <= 1'h1;
      repeat (3) @(posedge core_clk);
      coreReq <= 1'h1;
      repeat (4) @(posedge core_clk);
      coreReq <= 1'h0;
      #1;
      chk(busBusy_ff, 1'h0, "request refused");
      chk(addrOe_ff, 28'h0, "alt master address");
      @(posedge core_clk);
      altMaster <= 1'h0;
      do_reset(3'h2);
      finish_test;
   end
endmodule // tb
bind ebus_pin_unit ebus_pin_sva #(.NCS(NCS), .AW(AW)) chk_u (.*);
